// File: rtl/cmp_pkg.sv
// Purpose: shared constants for the four-channel comparator interrupt block
// Assumes: 32-bit apb data, one register per aligned word
// Notes: register offsets and the interrupt register pair are local choices
package cmp_pkg;
	localparam int NCH = 4;
	localparam int ADDR_W = 12;
	// register byte offsets
	localparam logic [11:0] OFF_STATUS = 12'h000;
	localparam logic [11:0] OFF_CONTROL = 12'h004;
	localparam logic [11:0] OFF_IRQ_STATUS = 12'h008;
	localparam logic [11:0] OFF_IRQ_MASK = 12'h00C;
	// comparator_control fields
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_IRQ_EN_LSB = 1;
	localparam int CTRL_POL0_BIT = 5;
	localparam int CTRL_POL1_BIT = 6;
	localparam int CTRL_POL23_BIT = 7;
	// comparator_result_flags fields
	localparam int STAT_LIVE_LSB = 0;
	localparam int STAT_FLAG_LSB = 4;
	// reset values
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [3:0] FLAG_RESET = 4'h0;
	localparam logic [3:0] PEND_RESET = 4'h0;
	localparam logic [3:0] MASK_RESET = 4'h0;
	// default slot of the combined interrupt in the high-priority irq register
	localparam int HIGH_PRIO_IRQ_POS = 2;
endpackage : cmp_pkg

// File: rtl/chan_if.sv
// Purpose: carries comparator channel state between core and synchroniser
// Assumes: single clock domain
// Notes: live, rise and fall are registered in the synchroniser
`timescale 1ns/1ps
interface chan_if #(parameter int N = 4);
	logic enable;
	logic [N-1:0] live;
	logic [N-1:0] rise;
	logic [N-1:0] fall;
	modport core (output enable, input live, input rise, input fall);
	modport chan (input enable, output live, output rise, output fall);
endinterface : chan_if

// File: rtl/chan_sync.sv
// Purpose: synchronise comparator outputs and detect their edges
// Assumes: comparator outputs are asynchronous to clk
// Notes: edges are reported one cycle, and only while the block is enabled
`timescale 1ns/1ps
module chan_sync #(
	parameter int N = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// raw comparator outputs
	input wire logic [N-1:0] raw,
	// towards the core
	chan_if.chan ch
);
	typedef struct packed {
		logic [N-1:0] s1;
		logic [N-1:0] s2;
		logic [N-1:0] prev;
		logic [N-1:0] live;
		logic [N-1:0] rise;
		logic [N-1:0] fall;
	} sync_t;

	sync_t r;
	sync_t n;

	always_comb
	begin
		n = r;
		n.s1 = raw;
		n.s2 = r.s1;
		// prev tracks even while off, so enabling does not fake an edge
		n.prev = r.s2;
		if (ch.enable)
		begin
			n.live = r.s2;
			n.rise = r.s2 & ~r.prev;
			n.fall = ~r.s2 & r.prev;
		end
		else
		begin
			// switched off: nothing compared, nothing reported
			n.live = '0;
			n.rise = '0;
			n.fall = '0;
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			r <= '0;
		else
			r <= n;
	end

	assign ch.live = r.live;
	assign ch.rise = r.rise;
	assign ch.fall = r.fall;

	a_sync_two_stage: assert property (@(posedge clk) disable iff (!nrst)
		ch.enable |=> ch.live == $past(raw, 3))
	else $error("live value does not follow the pin through the synchroniser");

	a_edge_vs_live: assert property (@(posedge clk) disable iff (!nrst)
		((ch.rise & ~ch.live) == '0) && ((ch.fall & ch.live) == '0))
	else $error("reported edge disagrees with live level");
endmodule : chan_sync

// File: rtl/lp_comparator_irq.sv
// Purpose: register and interrupt logic for four low-power comparators
// Assumes: apb slave with 32-bit data, comparator outputs asynchronous
// Notes: every transfer completes with one wait-free access phase
//
// Summary of operation
// - four channels; status bits 3:0 read live
// - control bit 0 switches the block on
// - one interrupt output, OR of unmasked pending channel events
// - control bits 4:1 enable channel 3:0 events
// - bits 5, 6 pick edges of channels 0, 1
// - bit 7 picks edge of channels 2, 3
// - status bits 7:4 sticky, cleared by reading
// - interrupt feeds high-priority irq position 2
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ps
module lp_comparator_irq #(
	parameter int N = cmp_pkg::NCH
) (
	// clock and reset
	input wire logic CLK,
	input wire logic NRST,
	// apb slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// comparator outputs
	input wire logic [N-1:0] CMP_OUT,
	// combined interrupt
	output logic IRQ
);
	typedef struct packed {
		logic [7:0] ctrl;
		logic [N-1:0] flag;
		logic [N-1:0] pend;
		logic [N-1:0] mask;
		logic [N-1:0] took;
		logic [31:0] rdata;
		logic ready;
		logic slverr;
		logic irq;
	} core_t;

	core_t r;
	core_t n;
	logic setup;
	logic access;
	logic wr_acc;
	logic rd_status;
	logic [3:0] pol;
	logic [N-1:0] ev;
	logic [N-1:0] rd_clear;
	logic [N-1:0] w1c;

	chan_if #(.N(N)) ch ();

	chan_sync #(.N(N)) u_sync (
		.clk(CLK),
		.nrst(NRST),
		.raw(CMP_OUT),
		.ch(ch)
	);

	assign ch.enable = r.ctrl[cmp_pkg::CTRL_ENABLE_BIT];

	// channels 2 and 3 share one polarity bit
	assign pol = {r.ctrl[cmp_pkg::CTRL_POL23_BIT],
		r.ctrl[cmp_pkg::CTRL_POL23_BIT],
		r.ctrl[cmp_pkg::CTRL_POL1_BIT],
		r.ctrl[cmp_pkg::CTRL_POL0_BIT]};

	for (genvar i = 0; i < N; i++)
	begin : g_event
		// a disabled channel raises no event; its live level still reads in status
		assign ev[i] = r.ctrl[cmp_pkg::CTRL_IRQ_EN_LSB + i]
			& (pol[i] ? ch.rise[i] : ch.fall[i]);
	end

	always_comb
	begin
		n = r;
		setup = PSEL && !PENABLE;
		access = PSEL && PENABLE && r.ready;
		wr_acc = access && PWRITE && PSTRB[0];
		rd_status = access && !PWRITE && (PADDR == cmp_pkg::OFF_STATUS);
		rd_clear = '0;
		w1c = '0;
		n.ready = setup;
		n.took = '0;
		if (setup)
		begin
			n.slverr = 1'b0;
			n.rdata = 32'h0000_0000;
			unique case (PADDR)
				cmp_pkg::OFF_STATUS:
				begin
					if (!PWRITE)
					begin
						n.rdata[cmp_pkg::STAT_LIVE_LSB +: N] = ch.live;
						n.rdata[cmp_pkg::STAT_FLAG_LSB +: N] = r.flag;
						// only flags actually returned may be cleared
						n.took = r.flag;
					end
				end
				cmp_pkg::OFF_CONTROL:
					n.rdata[7:0] = r.ctrl;
				cmp_pkg::OFF_IRQ_STATUS:
					n.rdata[N-1:0] = r.pend;
				cmp_pkg::OFF_IRQ_MASK:
					n.rdata[N-1:0] = r.mask;
				default:
					n.slverr = 1'b1;
			endcase
		end
		if (rd_status)
			rd_clear = r.took;
		if (wr_acc)
		begin
			unique case (PADDR)
				cmp_pkg::OFF_CONTROL:
					n.ctrl = PWDATA[7:0];
				cmp_pkg::OFF_IRQ_MASK:
					n.mask = PWDATA[N-1:0];
				cmp_pkg::OFF_IRQ_STATUS:
					w1c = PWDATA[N-1:0];
				default:
					w1c = '0;
			endcase
		end
		// set wins over clear in both sticky registers
		n.flag = (r.flag & ~rd_clear) | ev;
		n.pend = (r.pend & ~w1c) | ev;
		// combined line, wired to the high-priority slot cmp_pkg::HIGH_PRIO_IRQ_POS
		n.irq = |(n.pend & n.mask);
	end

	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			r.ctrl <= cmp_pkg::CTRL_RESET;
			r.flag <= cmp_pkg::FLAG_RESET;
			r.pend <= cmp_pkg::PEND_RESET;
			r.mask <= cmp_pkg::MASK_RESET;
			r.took <= '0;
			r.rdata <= 32'h0000_0000;
			r.ready <= 1'b0;
			r.slverr <= 1'b0;
			r.irq <= 1'b0;
		end
		else
			r <= n;
	end

	assign PRDATA = r.rdata;
	assign PREADY = r.ready;
	assign PSLVERR = r.slverr;
	assign IRQ = r.irq;

	a_live_read_value: assert property (@(posedge CLK) disable iff (!NRST)
		(PSEL && !PENABLE && !PWRITE && PADDR == cmp_pkg::OFF_STATUS)
		|=> PRDATA[3:0] == $past(ch.live))
	else $error("status read did not return live comparator values");

	a_flag_read_clear: assert property (@(posedge CLK) disable iff (!NRST)
		(PSEL && PENABLE && PREADY && !PWRITE && PADDR == cmp_pkg::OFF_STATUS
		&& ev == '0) |=> (r.flag & $past(r.took)) == '0)
	else $error("returned flags not cleared by the status read");

	a_event_kept: assert property (@(posedge CLK) disable iff (!NRST)
		(|ev) |=> (r.flag & $past(ev)) == $past(ev))
	else $error("channel event lost");

	a_disabled_quiet: assert property (@(posedge CLK) disable iff (!NRST)
		!r.ctrl[cmp_pkg::CTRL_ENABLE_BIT]
		|=> (ch.live == '0) && (ch.rise == '0) && (ch.fall == '0))
	else $error("comparator activity while disabled");

	a_chan_gate: assert property (@(posedge CLK) disable iff (!NRST)
		(!r.ctrl[cmp_pkg::CTRL_IRQ_EN_LSB] && !r.flag[0]) |=> !r.flag[0])
	else $error("disabled channel 0 raised a flag");

	a_irq_follows: assert property (@(posedge CLK) disable iff (!NRST)
		((|(ev & r.mask)) && !(PSEL && PENABLE && PWRITE)) |=> IRQ)
	else $error("unmasked event did not raise the interrupt");

	a_pol_rise0: assert property (@(posedge CLK) disable iff (!NRST)
		(r.ctrl[cmp_pkg::CTRL_POL0_BIT] && r.ctrl[cmp_pkg::CTRL_IRQ_EN_LSB]
		&& ch.rise[0]) |=> r.flag[0])
	else $error("rising edge on channel 0 not flagged");

	a_pol_fall_ignored: assert property (@(posedge CLK) disable iff (!NRST)
		(r.ctrl[cmp_pkg::CTRL_POL1_BIT] && !r.flag[1] && !ch.rise[1])
		|=> !r.flag[1])
	else $error("channel 1 flagged on the wrong edge");

	a_pol_shared: assert property (@(posedge CLK) disable iff (!NRST)
		(!r.ctrl[cmp_pkg::CTRL_POL23_BIT] && r.ctrl[cmp_pkg::CTRL_IRQ_EN_LSB + 3]
		&& ch.fall[3]) |=> r.flag[3])
	else $error("falling edge on channel 3 not flagged");

	a_ready_one_cycle: assert property (@(posedge CLK) disable iff (!NRST)
		(PSEL && !PENABLE) |=> PREADY ##1 !PREADY)
	else $error("pready not a single cycle after setup");

	a_unmapped_error: assert property (@(posedge CLK) disable iff (!NRST)
		(PSEL && !PENABLE && PADDR[11:4] != 8'h00) |=> PSLVERR && PRDATA == '0)
	else $error("unmapped access not answered with an error");

	a_idle_no_ready: assert property (@(posedge CLK) disable iff (!NRST)
		!PSEL
		|=> !PREADY)
	else $error("pready raised without a setup phase");

	a_mapped_no_error: assert property (@(posedge CLK) disable iff (!NRST)
		(PSEL && !PENABLE && PADDR[11:4] == 8'h00 && PADDR[1:0] == 2'h0)
		|=> !PSLVERR)
	else $error("mapped register answered with an error");

	a_rdata_hold: assert property (@(posedge CLK) disable iff (!NRST)
		!(PSEL && !PENABLE)
		|=> $stable(PRDATA))
	else $error("read data moved outside a setup phase");

	a_rdata_ctrl: assert property (@(posedge CLK) disable iff (!NRST)
		(PSEL && !PENABLE && !PWRITE && PADDR == cmp_pkg::OFF_CONTROL)
		|=> PRDATA == {24'h00_0000, $past(r.ctrl)})
	else $error("control read returned a wrong value");

	a_rdata_flags: assert property (@(posedge CLK) disable iff (!NRST)
		(PSEL && !PENABLE && !PWRITE && PADDR == cmp_pkg::OFF_STATUS)
		|=> PRDATA[cmp_pkg::STAT_FLAG_LSB +: N] == $past(r.flag) && PRDATA[31:8] == 24'h00_0000)
	else $error("status read returned wrong flags");

	a_rdata_pend: assert property (@(posedge CLK) disable iff (!NRST)
		(PSEL && !PENABLE && !PWRITE && PADDR == cmp_pkg::OFF_IRQ_STATUS)
		|=> PRDATA[N-1:0] == $past(r.pend))
	else $error("pending read returned a wrong value");

	a_rdata_mask: assert property (@(posedge CLK) disable iff (!NRST)
		(PSEL && !PENABLE && !PWRITE && PADDR == cmp_pkg::OFF_IRQ_MASK)
		|=> PRDATA[N-1:0] == $past(r.mask))
	else $error("mask read returned a wrong value");

	// register writes land only in an acknowledged access phase
	a_ctrl_write_lands: assert property (@(posedge CLK) disable iff (!NRST)
		(PSEL && PENABLE && PREADY && PWRITE && PSTRB[0]
		&& PADDR == cmp_pkg::OFF_CONTROL) |=> r.ctrl == $past(PWDATA[7:0]))
	else $error("control write did not land");

	a_mask_write_lands: assert property (@(posedge CLK) disable iff (!NRST)
		(PSEL && PENABLE && PREADY && PWRITE && PSTRB[0]
		&& PADDR == cmp_pkg::OFF_IRQ_MASK) |=> r.mask == $past(PWDATA[N-1:0]))
	else $error("mask write did not land");

	a_strobe_ignored: assert property (@(posedge CLK) disable iff (!NRST)
		(PSEL && PENABLE && PREADY && PWRITE && !PSTRB[0])
		|=> $stable(r.ctrl) && $stable(r.mask))
	else $error("write without byte strobe changed a register");

	a_ctrl_hold: assert property (@(posedge CLK) disable iff (!NRST)
		!(PSEL && PENABLE && PREADY && PWRITE)
		|=> $stable(r.ctrl) && $stable(r.mask))
	else $error("register changed without a write");

	a_error_no_write: assert property (@(posedge CLK) disable iff (!NRST)
		(PSEL && PENABLE && PREADY && PWRITE && PSLVERR)
		|=> $stable(r.ctrl) && $stable(r.mask))
	else $error("unmapped write changed a register");

	a_status_write_ignored: assert property (@(posedge CLK) disable iff (!NRST)
		(PSEL && PENABLE && PREADY && PWRITE && PADDR == cmp_pkg::OFF_STATUS)
		|=> $stable(r.ctrl) && $stable(r.mask))
	else $error("status write changed a register");

	a_pend_w1c: assert property (@(posedge CLK) disable iff (!NRST)
		(PSEL && PENABLE && PREADY && PWRITE && PSTRB[0] && ev == '0
		&& PADDR == cmp_pkg::OFF_IRQ_STATUS) |=> (r.pend & $past(PWDATA[N-1:0])) == '0)
	else $error("pending bit not cleared by writing one");

	// sticky bits move only on events, reads and clears
	a_flag_hold: assert property (@(posedge CLK) disable iff (!NRST)
		!(PSEL && PENABLE && PREADY && !PWRITE && PADDR == cmp_pkg::OFF_STATUS)
		|=> (r.flag & $past(r.flag)) == $past(r.flag))
	else $error("flag cleared without a status read");

	a_flag_needs_event: assert property (@(posedge CLK) disable iff (!NRST)
		ev == '0
		|=> (r.flag & ~$past(r.flag)) == '0)
	else $error("flag set without a channel event");

	a_pend_needs_event: assert property (@(posedge CLK) disable iff (!NRST)
		ev == '0
		|=> (r.pend & ~$past(r.pend)) == '0)
	else $error("pending bit set without a channel event");

	a_event_pending: assert property (@(posedge CLK) disable iff (!NRST)
		(|ev)
		|=> (r.pend & $past(ev)) == $past(ev))
	else $error("channel event did not set its pending bit");

	a_took_cleared: assert property (@(posedge CLK) disable iff (!NRST)
		!(PSEL && !PENABLE)
		|=> r.took == '0)
	else $error("stale returned flags kept after the access");

	a_irq_cause: assert property (@(posedge CLK) disable iff (!NRST)
		IRQ
		|-> (|(r.pend & r.mask)))
	else $error("interrupt high with no unmasked pending bit");

	a_mask_blocks: assert property (@(posedge CLK) disable iff (!NRST)
		r.mask == '0
		|-> !IRQ)
	else $error("interrupt high with every channel masked");

	a_ev_gate_all: assert property (@(posedge CLK) disable iff (!NRST)
		(|ev)
		|-> (ev & ~r.ctrl[cmp_pkg::CTRL_IRQ_EN_LSB +: N]) == '0)
	else $error("event from a channel with its interrupt disabled");

	// one cycle of history is needed: edges already in flight when the block stops
	a_off_no_flag: assert property (@(posedge CLK) disable iff (!NRST)
		(!r.ctrl[cmp_pkg::CTRL_ENABLE_BIT] && !$past(r.ctrl[cmp_pkg::CTRL_ENABLE_BIT])
		&& r.flag == '0) |=> r.flag == '0)
	else $error("flag raised while the block is off");

	a_ch1_fall: assert property (@(posedge CLK) disable iff (!NRST)
		(!r.ctrl[cmp_pkg::CTRL_POL1_BIT] && r.ctrl[cmp_pkg::CTRL_IRQ_EN_LSB + 1]
		&& ch.fall[1]) |=> r.flag[1])
	else $error("falling edge on channel 1 not flagged");

	a_ch0_wrong_edge: assert property (@(posedge CLK) disable iff (!NRST)
		(!r.ctrl[cmp_pkg::CTRL_POL0_BIT] && !r.flag[0] && !ch.fall[0])
		|=> !r.flag[0])
	else $error("channel 0 flagged on the wrong edge");

	a_ch2_rise: assert property (@(posedge CLK) disable iff (!NRST)
		(r.ctrl[cmp_pkg::CTRL_POL23_BIT] && r.ctrl[cmp_pkg::CTRL_IRQ_EN_LSB + 2]
		&& ch.rise[2]) |=> r.flag[2])
	else $error("rising edge on channel 2 not flagged");

	a_ch2_wrong_edge: assert property (@(posedge CLK) disable iff (!NRST)
		(r.ctrl[cmp_pkg::CTRL_POL23_BIT] && !r.flag[2] && !ch.rise[2])
		|=> !r.flag[2])
	else $error("channel 2 flagged on the wrong edge");
endmodule : lp_comparator_irq

// File: test/cmp_model.sv
// Purpose: behavioural comparator outputs facing the block
// Assumes: the bench requests one level per channel
// Notes: slow mode lags one extra cycle, like a sluggish analog edge
`timescale 1ns/1ps
module cmp_model (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// requested levels
	input wire logic [3:0] level,
	input wire logic slow,
	// comparator outputs
	output logic [3:0] cmp_out
);
	logic [3:0] lag_r;
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			lag_r <= 4'h0;
			cmp_out <= 4'h0;
		end
		else
		begin
			lag_r <= level;
			cmp_out <= slow ? lag_r : level;
		end
	end
endmodule : cmp_model

// File: test/tb_top.sv
// Purpose: self-checking bench for the comparator interrupt block
// Assumes: events settle within 10 cycles of a level change
// Notes: reads queue their expected data, a monitor compares them
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((e) !== (g)) begin error_cnt++; \
	$display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_top;
	logic CLK = 0;
	logic NRST = 0;
	logic PSEL = 0, PENABLE = 0, PWRITE = 0, slow = 0;
	logic [11:0] PADDR = 12'h000;
	logic [31:0] PWDATA = 32'h0, PRDATA;
	logic [3:0] PSTRB = 4'hF, CMP_OUT, lvl = 4'h0;
	logic PREADY, PSLVERR, IRQ;
	logic [32:0] expq[$];
	logic [32:0] ex;
	logic [15:0] lfsr = 16'h4620;
	int error_cnt = 0, n_tests = 0, cyc = 0;
	always #2.5 CLK = ~CLK;
	lp_comparator_irq u_lp_comparator_irq (.CLK(CLK), .NRST(NRST), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
		.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .CMP_OUT(CMP_OUT), .IRQ(IRQ));
	cmp_model u_cmp_model (.clk(CLK), .nrst(NRST), .level(lvl), .slow(slow), .cmp_out(CMP_OUT));
	function logic [15:0] next_rand();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr;
	endfunction : next_rand
	task report_and_stop();
		$display("counts: %0d checks, %0d mismatches", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop
	// idle edge at the end so a following call never re-drives psel in one step
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		PSTRB <= s;
		@(posedge CLK);
		PENABLE <= 1'b1;
		// pready ends this wait; with no local limit, only the bench timeout stops a hang
		do
		begin
			@(posedge CLK);
		end
		while (PREADY !== 1'b1);
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge CLK);
	endtask : xfer
	task rd(input logic [11:0] a, input logic [32:0] e);
		expq.push_back(e);
		xfer(1'b0, a, 32'h0, 4'hF);
	endtask : rd
	task wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, 4'hF);
	endtask : wr
	always @(posedge CLK)
	begin
		if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE)
		begin
			ex = expq.pop_front();
			`CHK("prdata", ex, {PSLVERR, PRDATA})
		end
	end
	always @(posedge CLK)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			error_cnt++;
			report_and_stop();
		end
	end
	initial
	begin
		logic [15:0] r;
		logic [7:0] ctrl;
		logic [3:0] fl, old;
		logic pol;
		repeat (16) @(posedge CLK);
		NRST <= 1'b1;
		@(posedge CLK);
		rd(cmp_pkg::OFF_STATUS, 33'h0);
		rd(cmp_pkg::OFF_CONTROL, 33'h0);
		rd(cmp_pkg::OFF_IRQ_STATUS, 33'h0);
		rd(cmp_pkg::OFF_IRQ_MASK, 33'h0);
		rd(12'h010, {1'b1, 32'h0});
		$display("test reset done");
		lvl <= 4'hF;
		repeat (10) @(posedge CLK);
		wr(cmp_pkg::OFF_STATUS, 32'hFF);
		rd(cmp_pkg::OFF_STATUS, 33'h0);
		xfer(1'b1, cmp_pkg::OFF_CONTROL, 32'hFF, 4'h0);
		wr(12'h010, 32'hFF);
		rd(cmp_pkg::OFF_CONTROL, 33'h0);
		wr(cmp_pkg::OFF_CONTROL, 32'h01);
		repeat (10) @(posedge CLK);
		rd(cmp_pkg::OFF_STATUS, 33'h0F);
		$display("test enable done");
		old = 4'hF;
		for (int i = 0; i < 16; i++)
		begin
			r = next_rand();
			ctrl = {r[7:1], 1'b1};
			wr(cmp_pkg::OFF_CONTROL, {24'h0, r[7:5], 5'h01});
			wr(cmp_pkg::OFF_CONTROL, {24'h0, ctrl});
			wr(cmp_pkg::OFF_IRQ_MASK, {28'h0, r[15:12]});
			lvl <= r[11:8];
			slow <= r[0];
			repeat (10) @(posedge CLK);
			for (int c = 0; c < 4; c++)
			begin
				pol = (c == 0) ? ctrl[5] : ((c == 1) ? ctrl[6] : ctrl[7]);
				fl[c] = ctrl[c + 1] & (pol ? (r[8 + c] & !old[c]) : (!r[8 + c] & old[c]));
			end
			rd(cmp_pkg::OFF_STATUS, {25'h0, fl, r[11:8]});
			rd(cmp_pkg::OFF_STATUS, {29'h0, r[11:8]});
			`CHK("irq", |(fl & r[15:12]), IRQ)
			rd(cmp_pkg::OFF_IRQ_STATUS, {29'h0, fl});
			wr(cmp_pkg::OFF_IRQ_STATUS, 32'hF);
			repeat (2) @(posedge CLK);
			`CHK("irq_clr", 1'b0, IRQ)
			old = r[11:8];
		end
		$display("test random done");
		wr(cmp_pkg::OFF_CONTROL, 32'h0);
		rd(cmp_pkg::OFF_STATUS, 33'h0);
		$display("test disable done");
		report_and_stop();
	end
endmodule : tb_top
